/* hdl/ubdm_pkg.sv */
/*
 * Shared constants and types for the bus adaptor DMA map and data path block.
 * Assumes a 12-bit register offset space and quadword (64-bit) memory words.
 */
package ubdm_pkg;
    // Array sizes
    localparam int NPATH = 16;
    localparam int NMAP = 496;
    // Register windows (byte offsets)
    localparam logic [11:0] PATH_BASE = 12'h040;
    localparam logic [11:0] PATH_LAST = 12'h07C;
    localparam logic [11:0] MAP_BASE = 12'h800;
    localparam logic [11:0] MAP_LAST = 12'hFBC;
    // Path status register fields
    localparam int PS_VALID = 31;
    localparam int PS_ERR = 30;
    // Page map entry fields
    localparam int MAP_VALID = 31;
    localparam int MAP_BO = 25;
    localparam int MAP_SEL = 21;
    localparam int SPA_IO = 20;
    // Reset and fill values
    localparam logic [31:0] MAP_RESET = 32'h0000_0000;
    localparam logic [7:0] FILL_FULL = 8'hFF;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WAIT = 2'h1
    } ubdm_state_e;

    typedef enum logic [1:0] {
        OP_DRD = 2'h0,
        OP_BRD = 2'h1,
        OP_DWR = 2'h2,
        OP_BWR = 2'h3
    } ubdm_op_e;

    // One memory request, quadword aligned longword address
    typedef struct packed {
        logic write;
        logic [27:0] addr;
        logic [63:0] data;
        logic [7:0] mask;
    } ubdm_mreq_s;

    // State of one buffered path
    typedef struct packed {
        logic valid;
        logic err;
        logic dir;
        logic [7:0] fill;
        logic [15:0] addr;
        logic [63:0] data;
    } ubdm_path_s;
endpackage

/* hdl/ubdm_top.sv */
/*
 * DMA page map, buffered data paths and memory request buffer of the adaptor.
 * Assumes the DMA master holds its request until ack or abort, and memory
 * answers every request in order with one response.
 */
`timescale 1ns/1ps
`default_nettype none
module ubdm_top (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_n_i,
    // Register access
    input wire logic reg_req_i,
    input wire logic reg_wr_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic reg_ack_o,
    output logic reg_busy_o,
    output logic reg_err_o,
    output logic [31:0] reg_rdata_o,
    // DMA master side
    input wire logic dma_req_i,
    input wire logic dma_write_i,
    input wire logic [17:0] dma_addr_i,
    input wire logic [15:0] dma_wdata_i,
    input wire logic [1:0] dma_be_i,
    output logic dma_ack_o,
    output logic dma_nxm_o,
    output logic dma_pb_o,
    output logic [15:0] dma_rdata_o,
    // Adaptor control and status
    input wire logic map_disable_i,
    output logic invalid_map_o,
    // Memory side
    output var ubdm_pkg::ubdm_mreq_s mem_req_o,
    output logic mem_valid_o,
    input wire logic mem_ready_i,
    input wire logic mem_rsp_valid_i,
    input wire logic mem_rsp_err_i,
    input wire logic [63:0] mem_rdata_i
);
    import ubdm_pkg::*;

    ubdm_path_s path_q [NPATH];
    ubdm_path_s path_d [NPATH];
    logic [31:0] map_q [NMAP];
    logic [31:0] map_d [NMAP];
    ubdm_state_e st_q, st_d;
    ubdm_op_e op_q, op_d;
    logic [3:0] cur_q, cur_d;
    logic [2:0] lane_q, lane_d;
    logic dack_q, dack_d, dnxm_q, dnxm_d, dpb_q, dpb_d, ivm_q, ivm_d;
    logic [15:0] drd_q, drd_d;
    logic rack_q, rack_d, rbusy_q, rbusy_d, rerr_q, rerr_d;
    logic [31:0] rrd_q, rrd_d;
    ubdm_mreq_s e0_q, e0_d, e1_q, e1_d, preq;
    logic v0_q, v0_d, v1_q, v1_d, push, pop;
    logic is_path, is_map, go, bo_eff;
    logic [3:0] pidx, sel;
    logic [8:0] midx;
    logic [31:0] ent;
    logic [18:0] pos;
    logic [2:0] lane;
    logic [27:0] qaddr;
    logic [63:0] wq, wbm;
    logic [7:0] wm;
    ubdm_path_s pq, np;

    // Entry lookup with a guard for the unmapped top pages
    function automatic logic [31:0] map_rd(input logic [8:0] i);
        map_rd = (32'(i) < NMAP) ? map_q[i] : MAP_RESET;
    endfunction

    // Flush request built from a buffer's captured address and fill bits
    function automatic ubdm_mreq_s flush_req(input ubdm_path_s p, input logic [31:0] m);
        flush_req.write = 1'h1;
        flush_req.addr = {m[20:0], p.addr[6:1], 1'h0};
        flush_req.data = p.data;
        flush_req.mask = p.fill;
    endfunction

    // Pick the 16-bit word starting at a byte lane
    function automatic logic [15:0] lane_word(input logic [63:0] d, input logic [2:0] l);
        logic [63:0] t;
        t = d >> {l, 3'h0};
        lane_word = t[15:0];
    endfunction

    // Address decode and page lookup
    assign is_path = (reg_addr_i >= PATH_BASE) && (reg_addr_i <= PATH_LAST) && (reg_addr_i[1:0] == 2'h0);
    assign is_map = (reg_addr_i >= MAP_BASE) && (reg_addr_i <= MAP_LAST) && (reg_addr_i[1:0] == 2'h0);
    assign pidx = reg_addr_i[5:2];
    assign midx = dma_addr_i[17:9];
    assign ent = map_rd(midx);
    assign sel = ent[MAP_SEL +: 4];
    assign pq = path_q[sel];
    // I/O space pages and the direct path never take the byte offset
    assign bo_eff = ent[MAP_BO] && (sel != 4'h0) && !ent[SPA_IO];
    assign pos = {1'h0, dma_addr_i} + {18'h0, bo_eff};
    assign lane = pos[2:0];
    assign qaddr = {ent[20:0], pos[8:3], 1'h0};
    // Requests are held off while a previous ack or abort is still showing
    assign go = (st_q == ST_IDLE) && dma_req_i && !reg_req_i && !dack_q && !dnxm_q && !v1_q;

    // Byte placement of write data; a high byte past lane 7 is dropped
    always_comb begin
        wq = 64'h0;
        wbm = 64'h0;
        wm = 8'h00;
        for (int k = 0; k < 8; k++) begin
            if (dma_be_i[0] && (4'(k) == {1'h0, lane})) begin
                wq[k*8 +: 8] = dma_wdata_i[7:0];
                wbm[k*8 +: 8] = 8'hFF;
                wm[k] = 1'h1;
            end
            if (dma_be_i[1] && (4'(k) == ({1'h0, lane} + 4'h1))) begin
                wq[k*8 +: 8] = dma_wdata_i[15:8];
                wbm[k*8 +: 8] = 8'hFF;
                wm[k] = 1'h1;
            end
        end
    end

    // Register, transfer and response sequencing
    always_comb begin
        path_d = path_q;
        map_d = map_q;
        st_d = st_q;
        op_d = op_q;
        cur_d = cur_q;
        lane_d = lane_q;
        dack_d = 1'h0;
        dnxm_d = 1'h0;
        dpb_d = 1'h0;
        ivm_d = 1'h0;
        drd_d = drd_q;
        rack_d = 1'h0;
        rbusy_d = 1'h0;
        rerr_d = 1'h0;
        rrd_d = 32'h0;
        push = 1'h0;
        preq = '0;
        np = pq;
        if (reg_req_i) begin
            if (is_path) begin
                if (st_q != ST_IDLE) begin
                    rbusy_d = 1'h1;
                end else if (!reg_wr_i) begin
                    rack_d = 1'h1;
                    if (pidx != 4'h0) begin
                        rrd_d = {path_q[pidx].valid, path_q[pidx].err, path_q[pidx].dir, 5'h00,
                                 path_q[pidx].fill, path_q[pidx].addr};
                    end
                end else if (pidx == 4'h0) begin
                    rack_d = 1'h1;
                end else if (reg_wdata_i[PS_VALID] && path_q[pidx].valid && path_q[pidx].dir && v1_q) begin
                    rbusy_d = 1'h1;
                end else begin
                    rack_d = 1'h1;
                    if (reg_wdata_i[PS_ERR]) begin
                        path_d[pidx].err = 1'h0;
                    end
                    if (reg_wdata_i[PS_VALID] && path_q[pidx].valid) begin
                        if (path_q[pidx].dir) begin
                            push = 1'h1;
                            preq = flush_req(path_q[pidx], map_rd(path_q[pidx].addr[15:7]));
                            st_d = ST_WAIT;
                            op_d = OP_BWR;
                            cur_d = pidx;
                        end else begin
                            path_d[pidx].valid = 1'h0;
                        end
                    end
                end
            end else if (is_map) begin
                rack_d = 1'h1;
                if (reg_wr_i) begin
                    map_d[reg_addr_i[10:2]] = reg_wdata_i;
                end else begin
                    rrd_d = map_q[reg_addr_i[10:2]];
                end
            end else begin
                rerr_d = 1'h1;
            end
        end else if (go) begin
            if (!ent[MAP_VALID]) begin
                dnxm_d = 1'h1;
                ivm_d = !map_disable_i;
            end else if ((sel != 4'h0) && pq.err) begin
                dnxm_d = 1'h1;
            end else if (!dma_write_i) begin
                if ((sel != 4'h0) && pq.valid) begin
                    dack_d = 1'h1;
                    drd_d = lane_word(pq.data, lane);
                end else begin
                    push = 1'h1;
                    preq = '{write: 1'h0, addr: qaddr, data: 64'h0, mask: 8'h00};
                    st_d = ST_WAIT;
                    op_d = (sel != 4'h0) ? OP_BRD : OP_DRD;
                    cur_d = sel;
                    lane_d = lane;
                end
            end else if (sel == 4'h0) begin
                push = 1'h1;
                preq = '{write: 1'h1, addr: qaddr, data: wq, mask: wm};
                st_d = ST_WAIT;
                op_d = OP_DWR;
            end else if (pq.valid && pq.dir && (pq.addr[15:1] != pos[17:3])) begin
                // New quadword: flush the old one first, the request is retried after
                push = 1'h1;
                preq = flush_req(pq, map_rd(pq.addr[15:7]));
                st_d = ST_WAIT;
                op_d = OP_BWR;
                cur_d = sel;
            end else begin
                if (!pq.valid || !pq.dir) begin
                    np.fill = 8'h00;
                end
                np.data = (pq.data & ~wbm) | wq;
                np.fill = np.fill | wm;
                np.valid = 1'h1;
                np.dir = 1'h1;
                np.addr = pos[17:2];
                path_d[sel] = np;
                dack_d = 1'h1;
                if (np.fill == FILL_FULL) begin
                    push = 1'h1;
                    preq = flush_req(np, ent);
                    st_d = ST_WAIT;
                    op_d = OP_BWR;
                    cur_d = sel;
                end
            end
        end
        // One outstanding memory operation; a buffered path serves one master
        if ((st_q == ST_WAIT) && mem_rsp_valid_i) begin
            st_d = ST_IDLE;
            case (op_q)
                OP_DRD, OP_BRD: begin
                    dack_d = 1'h1;
                    dpb_d = mem_rsp_err_i;
                    drd_d = lane_word(mem_rdata_i, lane_q);
                    if (op_q == OP_BRD) begin
                        path_d[cur_q].data = mem_rdata_i;
                        path_d[cur_q].valid = 1'h1;
                        path_d[cur_q].dir = 1'h0;
                        path_d[cur_q].fill = 8'h00;
                        path_d[cur_q].err = path_q[cur_q].err | mem_rsp_err_i;
                    end
                end
                OP_DWR: begin
                    dack_d = !mem_rsp_err_i;
                    dnxm_d = mem_rsp_err_i;
                end
                default: begin
                    path_d[cur_q].valid = 1'h0;
                    path_d[cur_q].fill = 8'h00;
                    path_d[cur_q].err = path_q[cur_q].err | mem_rsp_err_i;
                end
            endcase
        end
    end

    // Two-entry request buffer; head entry drives the memory port directly
    always_comb begin
        pop = v0_q && mem_ready_i;
        e0_d = e0_q;
        e1_d = e1_q;
        v0_d = v0_q;
        v1_d = v1_q;
        if (pop) begin
            e0_d = e1_q;
            v0_d = v1_q;
            v1_d = 1'h0;
        end
        if (push) begin
            if (!v0_d) begin
                e0_d = preq;
                v0_d = 1'h1;
            end else begin
                e1_d = preq;
                v1_d = 1'h1;
            end
        end
    end

    // State registers
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < NPATH; i++) begin
                path_q[i] <= '0;
            end
            for (int i = 0; i < NMAP; i++) begin
                map_q[i] <= MAP_RESET;
            end
            st_q <= ST_IDLE;
            op_q <= OP_DRD;
            cur_q <= 4'h0;
            lane_q <= 3'h0;
            {dack_q, dnxm_q, dpb_q, ivm_q} <= 4'h0;
            drd_q <= 16'h0;
            {rack_q, rbusy_q, rerr_q} <= 3'h0;
            rrd_q <= 32'h0;
            e0_q <= '0;
            e1_q <= '0;
            {v0_q, v1_q} <= 2'h0;
        end else begin
            path_q <= path_d;
            map_q <= map_d;
            st_q <= st_d;
            op_q <= op_d;
            cur_q <= cur_d;
            lane_q <= lane_d;
            {dack_q, dnxm_q, dpb_q, ivm_q} <= {dack_d, dnxm_d, dpb_d, ivm_d};
            drd_q <= drd_d;
            {rack_q, rbusy_q, rerr_q} <= {rack_d, rbusy_d, rerr_d};
            rrd_q <= rrd_d;
            e0_q <= e0_d;
            e1_q <= e1_d;
            {v0_q, v1_q} <= {v0_d, v1_d};
        end
    end

    assign reg_ack_o = rack_q;
    assign reg_busy_o = rbusy_q;
    assign reg_err_o = rerr_q;
    assign reg_rdata_o = rrd_q;
    assign dma_ack_o = dack_q;
    assign dma_nxm_o = dnxm_q;
    assign dma_pb_o = dpb_q;
    assign dma_rdata_o = drd_q;
    assign invalid_map_o = ivm_q;
    assign mem_req_o = e0_q;
    assign mem_valid_o = v0_q;

    a_path0_zero:
        assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
            reg_req_i && !reg_wr_i && (reg_addr_i == PATH_BASE) && (st_q == ST_IDLE) |=> reg_ack_o && (reg_rdata_o == 32'h0))
        else $error("path zero status not zero");
    a_hit_nomem:
        assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
            go && !dma_write_i && ent[MAP_VALID] && (sel != 4'h0) && pq.valid && !pq.err |=> dma_ack_o && (st_q == ST_IDLE))
        else $error("buffer hit did not answer at once");
    a_miss_fill:
        assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
            (st_q == ST_WAIT) && (op_q == OP_BRD) && mem_rsp_valid_i |=> path_q[cur_q].valid && !path_q[cur_q].dir && dma_ack_o)
        else $error("read miss did not fill buffer");
    a_purge_busy:
        assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
            (st_q == ST_WAIT) && reg_req_i && is_path |=> reg_busy_o && !reg_ack_o)
        else $error("path access not busy during flush");
    a_purge_zero:
        assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
            (st_q == ST_IDLE) && reg_req_i && reg_wr_i && (reg_addr_i == PATH_BASE) |=> (st_q == ST_IDLE) && !mem_valid_o ##0 reg_ack_o)
        else $error("purge of path zero started work");
    a_err_abort:
        assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
            go && ent[MAP_VALID] && (sel != 4'h0) && pq.err |=> dma_nxm_o && !dma_ack_o)
        else $error("transfer through failed path not aborted");
    a_parity_flag:
        assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
            (st_q == ST_WAIT) && !op_q[1] && mem_rsp_valid_i && mem_rsp_err_i |=> dma_pb_o && dma_ack_o)
        else $error("read parity error not flagged");
    a_map_invalid:
        assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
            go && !ent[MAP_VALID] |=> dma_nxm_o && (invalid_map_o == !$past(map_disable_i)))
        else $error("invalid entry not aborted");
    a_flush_clears:
        assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
            (st_q == ST_WAIT) && (op_q == OP_BWR) && mem_rsp_valid_i |=> !path_q[cur_q].valid && (path_q[cur_q].fill == 8'h00))
        else $error("flush did not empty buffer");
endmodule
`default_nettype wire

/* test/ubdm_mem_model.sv */
/*
 * Memory partner: one request at a time, answered in order, fast or slow,
 * failing a response on command.
 * Assumes the block holds mem_valid_o until it sees ready.
 */
`timescale 1ns/1ps
`default_nettype none
module ubdm_mem_model
    import ubdm_pkg::*;
(
    // Clock, reset and test controls
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic fail_i,
    // Request side
    input wire ubdm_pkg::ubdm_mreq_s req_i,
    input wire logic valid_i,
    output logic ready_o,
    // Response side
    output logic rsp_valid_o,
    output logic rsp_err_o,
    output logic [63:0] rdata_o
);
    logic [63:0] mem [logic [27:0]];
    logic [63:0] w;
    ubdm_mreq_s held;
    logic busy;
    int cnt;
    // Unwritten places read as an address pattern
    function automatic logic [63:0] rd(input logic [27:0] a);
        return mem.exists(a) ? mem[a] : {4'hA, a, 4'h5, a};
    endfunction
    // Accept, answer 2 or 201 cycles after the accept; rdata churns between answers
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ready_o <= 1'b0;
            busy <= 1'b0;
            cnt <= 0;
            rsp_valid_o <= 1'b0;
            rsp_err_o <= 1'b0;
            rdata_o <= 64'h0;
        end else begin
            rsp_valid_o <= 1'b0;
            rsp_err_o <= 1'b0;
            rdata_o <= ~rdata_o;
            if (valid_i && ready_o) begin
                ready_o <= 1'b0;
                busy <= 1'b1;
                cnt <= slow_i ? 200 : 1;
                held <= req_i;
            end else if (valid_i && !busy) begin
                ready_o <= 1'b1;
            end
            if (busy && cnt != 0) begin
                cnt <= cnt - 1;
            end else if (busy) begin
                busy <= 1'b0;
                rsp_valid_o <= 1'b1;
                rsp_err_o <= fail_i;
                rdata_o <= rd(held.addr);
                w = rd(held.addr);
                // Only masked bytes are written
                for (int b = 0; b < 8; b++) begin
                    if (held.mask[b]) w[8*b+:8] = held.data[8*b+:8];
                end
                if (held.write) mem[held.addr] = w;
            end
        end
    end
endmodule
`default_nettype wire

/* test/ubdm_top_tb.sv */
/*
 * Self-checking bench for ubdm_top with a memory partner and a map reference.
 * Assumes one-cycle register answers and DMA requests held until answered.
 */
`timescale 1ns/1ps
`default_nettype none
module ubdm_top_tb;
    import ubdm_pkg::*;
    logic clk, rst_n, rq, rwr, rack, rbsy, rerr, dq, dwr, dack, dnxm, dpb, mdis, inv;
    logic mv, mrdy, rspv, rspe, slow, fail;
    logic [11:0] radr;
    logic [31:0] rwd, rrd, r_data;
    logic [17:0] dadr, ua;
    logic [15:0] dwd, drd, d_data, lfsr_q;
    logic [15:0] w [4];
    logic [1:0] dbe;
    logic [63:0] map_disable_field;
    logic [2:0] r_kind;
    logic [3:0] d_kind;
    logic [31:0] map_m [NMAP];
    ubdm_mreq_s mreq, mlast;
    int fail_count, check_count, mreq_n, n0, k;

    ubdm_top dut (
        .sys_clk_i(clk), .reset_n_i(rst_n), .reg_req_i(rq), .reg_wr_i(rwr), .reg_addr_i(radr),
        .reg_wdata_i(rwd), .reg_ack_o(rack), .reg_busy_o(rbsy), .reg_err_o(rerr), .reg_rdata_o(rrd),
        .dma_req_i(dq), .dma_write_i(dwr), .dma_addr_i(dadr), .dma_wdata_i(dwd), .dma_be_i(dbe),
        .dma_ack_o(dack), .dma_nxm_o(dnxm), .dma_pb_o(dpb), .dma_rdata_o(drd),
        .map_disable_i(mdis), .invalid_map_o(inv), .mem_req_o(mreq), .mem_valid_o(mv),
        .mem_ready_i(mrdy), .mem_rsp_valid_i(rspv), .mem_rsp_err_i(rspe), .mem_rdata_i(map_disable_field)
    );
    ubdm_mem_model mem (
        .clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .fail_i(fail), .req_i(mreq), .valid_i(mv),
        .ready_o(mrdy), .rsp_valid_o(rspv), .rsp_err_o(rspe), .rdata_o(map_disable_field)
    );
    // 100 MHz clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Count accepted memory requests, keep the last
    always @(posedge clk) begin
        if (mv && mrdy) begin
            mreq_n++;
            mlast = mreq;
        end
    end
    // Random source, addresses, expected read lanes
    function automatic logic [15:0] rnd();
        lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
        return lfsr_q;
    endfunction
    function automatic logic [11:0] pa(input int p);
        return PATH_BASE + 12'(4 * p);
    endfunction
    function automatic logic [11:0] ma(input int i);
        return MAP_BASE + 12'(4 * i);
    endfunction
    function automatic logic [27:0] qa(input logic [17:0] a);
        return {map_m[a[17:9]][20:0], a[8:3], 1'b0};
    endfunction
    function automatic logic [15:0] lane(input logic [17:0] a);
        logic [63:0] q;
        q = {4'hA, qa(a), 4'h5, qa(a)};
        return q[16*a[2:1]+:16];
    endfunction
    // Valid entry with a random frame below I/O space
    function automatic logic [31:0] ent(input logic [3:0] sel, input logic off);
        return {1'b1, 5'h0, off, sel, 5'h0, rnd()};
    endfunction
    task automatic tally_and_finish();
        $display("Checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic hang();
        fail_count++;
        $display("MISMATCH answer expected some seen none");
        tally_and_finish();
    endtask
    task automatic check(input string n, input logic [127:0] seen, input logic [127:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // One register access, answer awaited four cycles at most
    task automatic rgo(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(negedge clk);
        rq = 1'b1;
        rwr = wr;
        radr = a;
        rwd = d;
        @(negedge clk);
        rq = 1'b0;
        r_kind = 3'b000;
        for (int i = 0; i < 4 && r_kind == 3'b000; i++) begin
            if (i > 0) @(negedge clk);
            r_kind = {rerr, rbsy, rack};
            r_data = rrd;
        end
        if (r_kind === 3'b000) hang();
    endtask
    task automatic rpoll(input logic [11:0] a);
        r_kind = 3'b010;
        for (int i = 0; i < 300 && r_kind == 3'b010; i++) rgo(1'b0, a, 32'h0);
        if (r_kind !== 3'b001) hang();
    endtask
    // DMA request held until done or aborted, then dropped
    task automatic dgo(input logic wr, input logic [17:0] a, input logic [15:0] d, input logic [1:0] be);
        @(negedge clk);
        dq = 1'b1;
        dwr = wr;
        dadr = a;
        dwd = d;
        dbe = be;
        d_kind = 4'h0;
        for (int i = 0; i < 400 && d_kind == 4'h0; i++) begin
            @(negedge clk);
            d_kind = {dpb, inv, dnxm, dack};
        end
        dq = 1'b0;
        d_data = drd;
        if (d_kind === 4'h0) hang();
    endtask
    // Map entry write, kept in the reference copy too
    task automatic mset(input int i, input logic [31:0] v);
        rgo(1'b1, ma(i), v);
        map_m[i] = v;
    endtask
    initial begin
        {rst_n, rq, rwr, dq, dwr, mdis, slow, fail} = 8'h00;
        {radr, rwd, dadr, dwd, dbe, lfsr_q} = {12'h000, 32'h0, 18'h0, 16'h0, 2'h0, 16'h84B7};
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        // Reset state, random map contents, unmapped address
        for (int p = 0; p < 16; p++) begin
            rgo(1'b0, pa(p), 32'h0);
            check("path_reset", {r_kind, r_data}, {3'b001, 32'h0});
        end
        rgo(1'b0, MAP_LAST, 32'h0);
        check("map_reset", {r_kind, r_data}, {3'b001, MAP_RESET});
        for (int i = 0; i < 4; i++) begin
            k = int'(rnd()) % NMAP;
            mset(k, {rnd(), rnd()});
            rgo(1'b0, ma(k), 32'h0);
            check("map_rw", {r_kind, r_data}, {3'b001, map_m[k]});
        end
        rgo(1'b0, 12'h000, 32'h0);
        check("unmapped", r_kind, 3'b100);
        n0 = mreq_n;
        rgo(1'b1, pa(0), 32'hC000_0000);
        rgo(1'b0, pa(0), 32'h0);
        check("purge_path0", {r_kind, r_data, 8'(mreq_n - n0)}, {3'b001, 32'h0, 8'h0});
        $display("Test registers done");
        // Invalid entries, masked report, page beyond the table
        mset(7, 32'h0);
        dgo(1'b0, {9'd7, 9'h000}, 16'h0, 2'b00);
        check("invalid_entry", d_kind, 4'b0110);
        mdis = 1'b1;
        dgo(1'b0, {9'd7, 9'h002}, 16'h0, 2'b00);
        check("masked_invalid", d_kind, 4'b0010);
        mdis = 1'b0;
        dgo(1'b1, {9'd496, 9'h000}, 16'h1234, 2'b11);
        check("past_table", d_kind, 4'b0110);
        // Direct path ignores the offset bit
        mset(2, ent(4'h0, 1'b1));
        ua = {9'd2, 9'h1C6};
        dgo(1'b0, ua, 16'h0, 2'b00);
        check("direct_read", {d_kind, d_data}, {4'b0001, lane(ua)});
        check("direct_addr", {mlast.write, mlast.addr}, {1'b0, qa(ua)});
        dgo(1'b1, ua, 16'h5AA5, 2'b11);
        check("direct_write", {d_kind, mlast.write, mlast.mask, mlast.data[63:48]},
              {4'b0001, 1'b1, 8'hC0, 16'h5AA5});
        // Buffered read: miss fills, hit reuses, purge only empties
        mset(3, ent(4'h1, 1'b0));
        ua = {9'd3, 9'h010};
        dgo(1'b0, ua, 16'h0, 2'b00);
        check("miss_read", {d_kind, d_data, mlast.addr}, {4'b0001, lane(ua), qa(ua)});
        n0 = mreq_n;
        rgo(1'b0, pa(1), 32'h0);
        check("read_path", {r_kind, r_data[31:29]}, {3'b001, 3'b100});
        dgo(1'b0, ua + 18'h4, 16'h0, 2'b00);
        check("hit_read", {d_kind, d_data, 8'(mreq_n - n0)}, {4'b0001, lane(ua + 18'h4), 8'h0});
        rgo(1'b1, pa(1), 32'h8000_0000);
        rgo(1'b0, pa(1), 32'h0);
        check("read_purge", {r_data[31], 8'(mreq_n - n0)}, {1'b0, 8'h0});
        $display("Test reads done");
        // Buffered write, then a slow flush
        mset(4, ent(4'h2, 1'b0));
        ua = {9'd4, 9'h020};
        dgo(1'b1, ua, 16'hA1B2, 2'b11);
        dgo(1'b1, ua + 18'h2, 16'h00C3, 2'b01);
        rgo(1'b0, pa(2), 32'h0);
        check("write_path", {d_kind, r_data}, {4'b0001, 8'hA0, 8'h07, ua[17:2]});
        slow = 1'b1;
        n0 = mreq_n;
        rgo(1'b1, pa(2), 32'h8000_0000);
        rgo(1'b0, pa(2), 32'h0);
        check("flush_busy", r_kind, 3'b010);
        rpoll(pa(2));
        slow = 1'b0;
        check("flush", {8'(mreq_n - n0), mlast.write, mlast.addr, mlast.mask, mlast.data[23:0]},
              {8'h1, 1'b1, qa(ua), 8'h07, 24'hC3A1B2});
        check("flushed", {r_data[31], r_data[23:16]}, 9'h000);
        // Offset write lands a byte up; empty purge does nothing
        mset(5, ent(4'h3, 1'b1));
        ua = {9'd5, 9'h040};
        n0 = mreq_n;
        dgo(1'b1, ua, 16'hBEEF, 2'b11);
        rgo(1'b1, pa(3), 32'h8000_0000);
        rpoll(pa(3));
        check("offset_flush", {mlast.mask, mlast.data[23:8]}, {8'h06, 16'hBEEF});
        rgo(1'b1, pa(3), 32'h8000_0000);
        check("empty_purge", {r_kind, 8'(mreq_n - n0)}, {3'b001, 8'h1});
        $display("Test writes done");
        // Failed flush sets a sticky error that blocks the path
        mset(6, ent(4'h4, 1'b0));
        ua = {9'd6, 9'h000};
        dgo(1'b1, ua, rnd(), 2'b11);
        fail = 1'b1;
        rgo(1'b1, pa(4), 32'h8000_0000);
        rpoll(pa(4));
        fail = 1'b0;
        check("flush_error", r_data[31:30], 2'b01);
        dgo(1'b1, ua, 16'h5555, 2'b11);
        check("error_abort", d_kind, 4'b0010);
        rgo(1'b1, pa(4), 32'h8000_0000);
        rgo(1'b0, pa(4), 32'h0);
        check("purge_keeps", r_data[30], 1'b1);
        rgo(1'b1, pa(4), 32'h4000_0000);
        dgo(1'b1, ua, 16'h5555, 2'b11);
        check("after_clear", d_kind, 4'b0001);
        // Read parity failure, then abort on next access
        mset(8, ent(4'h5, 1'b0));
        ua = {9'd8, 9'h000};
        fail = 1'b1;
        dgo(1'b0, ua, 16'h0, 2'b00);
        fail = 1'b0;
        check("parity_read", {d_kind, d_data}, {4'b1001, lane(ua)});
        dgo(1'b0, ua, 16'h0, 2'b00);
        check("parity_next", d_kind, 4'b0010);
        rgo(1'b1, pa(5), 32'h4000_0000);
        // Full quadword of random words flushes by itself
        mset(9, ent(4'h6, 1'b0));
        ua = {9'd9, 9'h0F8};
        n0 = mreq_n;
        for (int i = 0; i < 4; i++) begin
            w[i] = rnd();
            dgo(1'b1, ua + 18'(2 * i), w[i], 2'b11);
        end
        for (int i = 0; i < 50 && mreq_n == n0; i++) @(negedge clk);
        if (mreq_n == n0) hang();
        rpoll(pa(6));
        check("full_flush", {8'(mreq_n - n0), mlast.mask, mlast.data},
              {8'h1, FILL_FULL, w[3], w[2], w[1], w[0]});
        $display("Test errors done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
